/* File: bcce_top.sv */
// execute unit for branches, two-word call, clear-file, clear-watchdog and toggle
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module bcce_top (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [7:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [7:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   output logic [bcce_pkg::PC_W-1:0]         prog_addr,
   input  wire logic [15:0]                  prog_rdata,
   output bcce_pkg::bcce_dm_req_t            dm_req,
   input  wire logic [7:0]                   dm_rdata,
   output logic                              watchdog_clear
);
   typedef struct packed {
      bcce_pkg::bcce_mode_t      mode;
      bcce_pkg::bcce_q_t         q;
      bcce_pkg::bcce_op_t        op;
      logic [15:0]               ir;
      logic [bcce_pkg::PC_W-1:0] iaddr;
      logic [bcce_pkg::PC_W-1:0] pc;
      logic [7:0]                working;
      logic [7:0]                working_shadow;
      logic [4:0]                status;
      logic [4:0]                status_shadow;
      logic [3:0]                bank_select_reg;
      logic [3:0]                bank_select_shadow;
      logic [7:0]                rd;
      logic                      taken;
      logic                      run;
      logic                      timeout_flag;
      logic                      powerdown_flag;
      logic                      wdog_clr;
      logic                      push;
      logic [bcce_pkg::PC_W-1:0] push_data;
      bcce_pkg::bcce_dm_req_t    dm;
      logic                      awready;
      logic                      wready;
      logic                      aw_got;
      logic                      w_got;
      logic [7:0]                awaddr;
      logic [31:0]               wdata;
      logic [3:0]                wstrb;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      arready;
      logic                      rvalid;
      logic [1:0]                rresp;
      logic [31:0]               rdata;
   } bcce_state_t;

   bcce_state_t               s_q;
   bcce_state_t               s_d;
   bcce_pkg::bcce_op_t        dec_op;
   logic [bcce_pkg::PC_W-1:0] rtop;
   logic [bcce_pkg::SP_W-1:0] sp;
   logic [31:0]               wr_merged;

   function automatic logic mapped(logic [7:0] a);
      return a == bcce_pkg::REG_CTRL || a == bcce_pkg::REG_STATUS
          || a == bcce_pkg::REG_WREG || a == bcce_pkg::REG_BNK
          || a == bcce_pkg::REG_PC || a == bcce_pkg::REG_TOP
          || a == bcce_pkg::REG_SHADOW || a == bcce_pkg::REG_WDOG
          || a == bcce_pkg::REG_EXEC;
   endfunction

   // read view; also the base that a strobed write merges into
   function automatic logic [31:0] regval(logic [7:0] a, bcce_state_t s,
                                          logic [bcce_pkg::PC_W-1:0] t,
                                          logic [bcce_pkg::SP_W-1:0] p);
      logic [31:0] r;
      r = '0;
      case (a)
         bcce_pkg::REG_CTRL: begin
            r[bcce_pkg::CTRL_RUN] = s.run;
         end
         bcce_pkg::REG_STATUS: begin
            r[4:0] = s.status;
         end
         bcce_pkg::REG_WREG: begin
            r[7:0] = s.working;
         end
         bcce_pkg::REG_BNK: begin
            r[3:0] = s.bank_select_reg;
         end
         bcce_pkg::REG_PC: begin
            r[bcce_pkg::PC_W-1:0] = s.pc;
         end
         bcce_pkg::REG_TOP: begin
            r[bcce_pkg::PC_W-1:0] = t;
            r[bcce_pkg::TOP_SP_LSB +: bcce_pkg::SP_W] = p;
         end
         bcce_pkg::REG_SHADOW: begin
            r[7:0] = s.working_shadow;
            r[bcce_pkg::SH_ST_LSB +: 5] = s.status_shadow;
            r[bcce_pkg::SH_BNK_LSB +: 4] = s.bank_select_shadow;
         end
         bcce_pkg::REG_WDOG: begin
            r[bcce_pkg::WDOG_TMO] = s.timeout_flag;
            r[bcce_pkg::WDOG_PWD] = s.powerdown_flag;
         end
         bcce_pkg::REG_EXEC: begin
            r[15:0] = s.ir;
            r[bcce_pkg::EX_Q_LSB +: 2] = s.q;
            r[bcce_pkg::EX_MODE_LSB +: 2] = s.mode;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   function automatic bcce_pkg::bcce_q_t next_q(bcce_pkg::bcce_q_t q);
      case (q)
         bcce_pkg::Q1: return bcce_pkg::Q2;
         bcce_pkg::Q2: return bcce_pkg::Q3;
         bcce_pkg::Q3: return bcce_pkg::Q4;
         default: return bcce_pkg::Q1;
      endcase
   endfunction

   function automatic logic [bcce_pkg::DM_AW-1:0] bank_addr(logic acc, logic [3:0] bank,
                                                            logic [7:0] f);
      logic [3:0] b;
      b = bank;
      if (!acc) begin
         b = (f < bcce_pkg::ACC_SPLIT) ? bcce_pkg::ACC_LO_BANK : bcce_pkg::ACC_HI_BANK;
      end
      return {b, f};
   endfunction

   // signed offset doubled onto the incremented counter
   function automatic logic [bcce_pkg::PC_W-1:0] br_target(logic [bcce_pkg::PC_W-1:0] ia,
                                                           logic [7:0] n);
      logic [bcce_pkg::PC_W-1:0] off2;
      off2 = {{(bcce_pkg::PC_W-9){n[7]}}, n, 1'b0};
      return ia + bcce_pkg::PC_STEP + off2;
   endfunction

   bcce_decode u_decode (
      .word (prog_rdata),
      .op   (dec_op)
   );

   bcce_ret_stack u_stack (
      .aclk    (aclk),
      .aresetn (aresetn),
      .push    (s_q.push),
      .din     (s_q.push_data),
      .top     (rtop),
      .sp      (sp)
   );

   assign wr_merged = bcce_pkg::wmerge(regval(s_q.awaddr, s_q, rtop, sp), s_q.wdata,
                                       s_q.wstrb);

   always_comb begin
      s_d         = s_q;
      s_d.push    = 1'b0;
      s_d.wdog_clr = 1'b0;
      s_d.dm.we   = 1'b0;
      s_d.dm.re   = 1'b0;

      // register bus: address and data taken in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_axi_bready && s_q.bvalid) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = mapped(s_q.awaddr) ? bcce_pkg::RESP_OKAY : bcce_pkg::RESP_SLVERR;
         case (s_q.awaddr)
            bcce_pkg::REG_CTRL: begin
               s_d.run = wr_merged[bcce_pkg::CTRL_RUN];
            end
            bcce_pkg::REG_STATUS: begin
               s_d.status = wr_merged[4:0];
            end
            bcce_pkg::REG_WREG: begin
               s_d.working = wr_merged[7:0];
            end
            bcce_pkg::REG_BNK: begin
               s_d.bank_select_reg = wr_merged[3:0];
            end
            bcce_pkg::REG_PC: begin
               // moving the counter under a running core would split an instruction
               if (s_q.mode == bcce_pkg::MODE_HALT) begin
                  s_d.pc = {wr_merged[bcce_pkg::PC_W-1:1], 1'b0};
               end
            end
            bcce_pkg::REG_WDOG: begin
               if (s_q.wstrb[0] && s_q.wdata[bcce_pkg::WDOG_TMO]) begin
                  s_d.timeout_flag = 1'b0;
               end
               if (s_q.wstrb[0] && s_q.wdata[bcce_pkg::WDOG_PWD]) begin
                  s_d.powerdown_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (s_axi_rready && s_q.rvalid) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = regval(s_axi_araddr, s_q, rtop, sp);
         s_d.rresp  = mapped(s_axi_araddr) ? bcce_pkg::RESP_OKAY : bcce_pkg::RESP_SLVERR;
      end

      // core sequencing; placed after the bus so that hardware flag sets win
      case (s_q.mode)
         bcce_pkg::MODE_HALT: begin
            if (s_q.run) begin
               s_d.mode = bcce_pkg::MODE_EXEC;
            end
         end
         bcce_pkg::MODE_NOP: begin
            s_d.op = bcce_pkg::OP_NONE;
            s_d.q  = next_q(s_q.q);
            if (s_q.q == bcce_pkg::Q4) begin
               s_d.mode = bcce_pkg::MODE_EXEC;
            end
         end
         bcce_pkg::MODE_EXEC: begin
            s_d.q = next_q(s_q.q);
            case (s_q.q)
               bcce_pkg::Q1: begin
                  if (!s_q.run) begin
                     s_d.mode = bcce_pkg::MODE_HALT;
                     s_d.q    = bcce_pkg::Q1;
                  end else begin
                     s_d.ir    = prog_rdata;
                     s_d.op    = dec_op;
                     s_d.iaddr = s_q.pc;
                     s_d.pc    = s_q.pc + bcce_pkg::PC_STEP;
                     s_d.taken = 1'b0;
                  end
               end
               bcce_pkg::Q2: begin
                  if (s_q.op == bcce_pkg::OP_CLF || s_q.op == bcce_pkg::OP_TGL) begin
                     s_d.dm.re   = 1'b1;
                     s_d.dm.addr = bank_addr(s_q.ir[bcce_pkg::ACC_BIT], s_q.bank_select_reg,
                                             s_q.ir[7:0]);
                  end
               end
               bcce_pkg::Q3: begin
                  s_d.rd = dm_rdata;
                  case (s_q.op)
                     bcce_pkg::OP_BRV: s_d.taken = s_q.status[bcce_pkg::ST_OV];
                     bcce_pkg::OP_BRZ: s_d.taken = s_q.status[bcce_pkg::ST_Z];
                     bcce_pkg::OP_CALL: begin
                        s_d.push      = 1'b1;
                        s_d.push_data = s_q.iaddr + bcce_pkg::CALL_STEP;
                        if (s_q.ir[bcce_pkg::CALL_S_BIT]) begin
                           s_d.working_shadow     = s_q.working;
                           s_d.status_shadow      = s_q.status;
                           s_d.bank_select_shadow = s_q.bank_select_reg;
                        end
                     end
                     bcce_pkg::OP_CLWD: begin
                        s_d.wdog_clr       = 1'b1;
                        s_d.timeout_flag   = 1'b1;
                        s_d.powerdown_flag = 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
               default: begin
                  case (s_q.op)
                     bcce_pkg::OP_BRV, bcce_pkg::OP_BRZ: begin
                        if (s_q.taken) begin
                           s_d.pc   = br_target(s_q.iaddr, s_q.ir[7:0]);
                           s_d.mode = bcce_pkg::MODE_NOP;
                        end
                     end
                     bcce_pkg::OP_CALL: begin
                        // second word holds target bits 20:9
                        s_d.pc   = {prog_rdata[11:0], s_q.ir[7:0], 1'b0};
                        s_d.mode = bcce_pkg::MODE_NOP;
                     end
                     bcce_pkg::OP_CLF: begin
                        s_d.dm.we                 = 1'b1;
                        s_d.dm.wdata              = 8'h00;
                        s_d.status[bcce_pkg::ST_Z] = 1'b1;
                     end
                     bcce_pkg::OP_TGL: begin
                        s_d.dm.we    = 1'b1;
                        s_d.dm.wdata = s_q.rd ^ (8'h01 << s_q.ir[bcce_pkg::BIT_LSB +: 3]);
                     end
                     // no other flag is written here
                     default: begin
                     end
                  endcase
               end
            endcase
         end
         default: begin
            s_d.mode = bcce_pkg::MODE_HALT;
         end
      endcase

      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;

      if (!aresetn) begin
         s_d                = '0;
         s_d.run            = bcce_pkg::RUN_RST;
         s_d.timeout_flag   = bcce_pkg::TMO_RST;
         s_d.powerdown_flag = bcce_pkg::PWD_RST;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign s_axi_awready  = s_q.awready;
   assign s_axi_wready   = s_q.wready;
   assign s_axi_bvalid   = s_q.bvalid;
   assign s_axi_bresp    = s_q.bresp;
   assign s_axi_arready  = s_q.arready;
   assign s_axi_rvalid   = s_q.rvalid;
   assign s_axi_rresp    = s_q.rresp;
   assign s_axi_rdata    = s_q.rdata;
   assign prog_addr      = s_q.pc;
   assign dm_req         = s_q.dm;
   assign watchdog_clear = s_q.wdog_clr;
endmodule

/* File: bcce_pkg.sv */
// constants, types and helpers of the branch, call and clear execute block
package bcce_pkg;
   localparam int unsigned PC_W        = 21;
   localparam int unsigned SP_W        = 5;
   localparam int unsigned STACK_DEPTH = 31;
   localparam int unsigned DM_AW       = 12;
   localparam int unsigned STATUS_W    = 5;
   localparam logic [7:0]  OPC_BRV     = 8'hE4;
   localparam logic [7:0]  OPC_BRZ     = 8'hE0;
   localparam logic [6:0]  OPC_CALL    = 7'h76;
   localparam logic [6:0]  OPC_CLF     = 7'h35;
   localparam logic [15:0] OPC_CLWD    = 16'h0004;
   localparam logic [3:0]  OPC_TGL     = 4'h7;
   localparam int unsigned CALL_S_BIT  = 8;
   localparam int unsigned ACC_BIT     = 8;
   localparam int unsigned BIT_LSB     = 9;
   localparam logic [7:0]  ACC_SPLIT   = 8'h80;
   localparam logic [3:0]  ACC_HI_BANK = 4'hF;
   localparam logic [3:0]  ACC_LO_BANK = 4'h0;
   localparam int unsigned ST_Z        = 2;
   localparam int unsigned ST_OV       = 3;
   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [PC_W-1:0] CALL_STEP = 21'h000004;
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_WREG    = 8'h08;
   localparam logic [7:0]  REG_BNK     = 8'h0C;
   localparam logic [7:0]  REG_PC      = 8'h10;
   localparam logic [7:0]  REG_TOP     = 8'h14;
   localparam logic [7:0]  REG_SHADOW  = 8'h18;
   localparam logic [7:0]  REG_WDOG    = 8'h1C;
   localparam logic [7:0]  REG_EXEC    = 8'h20;
   localparam int unsigned CTRL_RUN    = 0;
   localparam int unsigned WDOG_TMO    = 0;
   localparam int unsigned WDOG_PWD    = 1;
   localparam int unsigned SH_ST_LSB   = 8;
   localparam int unsigned SH_BNK_LSB  = 16;
   localparam int unsigned TOP_SP_LSB  = 24;
   localparam int unsigned EX_Q_LSB    = 16;
   localparam int unsigned EX_MODE_LSB = 20;
   localparam logic        RUN_RST     = 1'b0;
   localparam logic        TMO_RST     = 1'b1;
   localparam logic        PWD_RST     = 1'b1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_HALT, MODE_EXEC, MODE_NOP} bcce_mode_t;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bcce_q_t;
   typedef enum logic [2:0] {OP_NONE, OP_BRV, OP_BRZ, OP_CALL, OP_CLF, OP_CLWD,
                             OP_TGL} bcce_op_t;

   typedef struct packed {
      logic [DM_AW-1:0] addr;
      logic [7:0]       wdata;
      logic             we;
      logic             re;
   } bcce_dm_req_t;

   function automatic logic [31:0] wmerge(logic [31:0] old_v, logic [31:0] new_v,
                                          logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage

/* File: bcce_decode.sv */
// opcode decoder for the branch, call, clear and toggle group
`timescale 1ns/1ps
module bcce_decode (
   input  wire logic [15:0]   word,
   output bcce_pkg::bcce_op_t op
);
   always_comb begin
      op = bcce_pkg::OP_NONE;
      if (word[15:8] == bcce_pkg::OPC_BRV) begin
         op = bcce_pkg::OP_BRV;
      end else if (word[15:8] == bcce_pkg::OPC_BRZ) begin
         op = bcce_pkg::OP_BRZ;
      end else if (word[15:9] == bcce_pkg::OPC_CALL) begin
         op = bcce_pkg::OP_CALL;
      end else if (word[15:9] == bcce_pkg::OPC_CLF) begin
         op = bcce_pkg::OP_CLF;
      end else if (word == bcce_pkg::OPC_CLWD) begin
         op = bcce_pkg::OP_CLWD;
      end else if (word[15:12] == bcce_pkg::OPC_TGL) begin
         op = bcce_pkg::OP_TGL;
      end
   end
endmodule

/* File: bcce_ret_stack.sv */
// hardware return stack holding call return addresses
`timescale 1ns/1ps
module bcce_ret_stack (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      push,
   input  wire logic [bcce_pkg::PC_W-1:0] din,
   output logic      [bcce_pkg::PC_W-1:0] top,
   output logic      [bcce_pkg::SP_W-1:0] sp
);
   localparam logic [bcce_pkg::SP_W-1:0] FULL = bcce_pkg::SP_W'(bcce_pkg::STACK_DEPTH);

   logic [bcce_pkg::PC_W-1:0] mem [bcce_pkg::STACK_DEPTH];
   logic [bcce_pkg::SP_W-1:0] sp_q;
   logic [bcce_pkg::SP_W-1:0] sp_d;
   logic [bcce_pkg::SP_W-1:0] wr_idx;

   // a push into a full stack overwrites the newest entry
   always_comb begin
      wr_idx = (sp_q == FULL) ? sp_q - 5'h01 : sp_q;
      sp_d   = (push && sp_q != FULL) ? sp_q + 5'h01 : sp_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_q <= '0;
      end else begin
         sp_q <= sp_d;
      end
      if (push) begin
         mem[wr_idx] <= din;
      end
   end

   assign top = (sp_q == 5'h00) ? '0 : mem[sp_q - 5'h01];
   assign sp  = sp_q;
endmodule

/* File: bcce_properties.sv */
// port checker of the execute block, bound to its top module
`timescale 1ns/1ps
module bcce_properties (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [bcce_pkg::PC_W-1:0] prog_addr,
   input  wire logic [15:0]              prog_rdata,
   input  wire bcce_pkg::bcce_dm_req_t   dm_req,
   input  wire logic [7:0]               dm_rdata,
   input  wire logic                     watchdog_clear
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a fetch is a branch word seen while the counter steps by one word
   sequence s_br_fetch;
      (prog_rdata[15:8] == bcce_pkg::OPC_BRZ || prog_rdata[15:8] == bcce_pkg::OPC_BRV)
      ##1 prog_addr == $past(prog_addr) + bcce_pkg::PC_STEP;
   endsequence
   sequence s_call_fetch;
      prog_rdata[15:9] == bcce_pkg::OPC_CALL ##1 prog_addr == $past(prog_addr) + bcce_pkg::PC_STEP;
   endsequence
   sequence s_rmw;
      dm_req.re ##1 !dm_req.re && !dm_req.we ##1 dm_req.we;
   endsequence
   chk_br_target: assert property (s_br_fetch |-> ##3 (
      prog_addr == $past(prog_addr, 4) + bcce_pkg::PC_STEP || prog_addr == $past(prog_addr, 4)
      + bcce_pkg::PC_STEP + {{12{$past(prog_rdata[7], 4)}}, $past(prog_rdata[7:0], 4), 1'b0}))
      else $error("branch target wrong");
   chk_br_idle: assert property (s_br_fetch ##3 $changed(prog_addr) |=>
      $stable(prog_addr) [*4]) else $error("taken branch not idle");
   chk_call_target: assert property (s_call_fetch |-> ##3 (
      prog_addr[20:9] == $past(prog_rdata[11:0]) && prog_addr[8:1] == $past(prog_rdata[7:0], 4))
      ##1 $stable(prog_addr) [*4]) else $error("call target wrong");
   chk_file_seq: assert property (dm_req.re |-> s_rmw)
      else $error("read modify write order wrong");
   chk_bank_hold: assert property (dm_req.re |=> $stable(dm_req.addr) [*2])
      else $error("data address moved");
   chk_write_value: assert property (dm_req.we |-> dm_req.wdata == 8'h00 ||
      $onehot(dm_req.wdata ^ $past(dm_rdata, 2))) else $error("written value wrong");
   chk_wclr_pulse: assert property ($rose(watchdog_clear) |=> !watchdog_clear [*3])
      else $error("watchdog clear not one pulse");
   chk_pc_even: assert property (prog_addr[0] == 1'b0)
      else $error("odd program address");
endmodule

bind bcce_top bcce_properties u_chk (.aclk(aclk), .aresetn(aresetn), .prog_addr(prog_addr),
   .prog_rdata(prog_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata), .watchdog_clear(watchdog_clear));

/* File: bcce_partner.sv */
// program memory and data register file beside the execute block
`timescale 1ns/1ps
module bcce_partner (
   input  wire logic                     aclk,
   input  wire logic [bcce_pkg::PC_W-1:0] prog_addr,
   output logic      [15:0]              prog_rdata,
   input  wire bcce_pkg::bcce_dm_req_t   dm_req,
   output logic      [7:0]               dm_rdata
);
   logic [15:0] pmem [0:1023];
   logic [7:0]  dmem [0:4095];
   // upper address bits wrap, so far call targets alias into this memory
   assign prog_rdata = pmem[prog_addr[10:1]];
   // read line outside a read shows the inverse, never a stale copy
   assign dm_rdata = dm_req.re ? dmem[dm_req.addr] : ~dmem[dm_req.addr];
   always @(posedge aclk) begin
      if (dm_req.we) dmem[dm_req.addr] <= dm_req.wdata;
   end
endmodule

/* File: bcce_top_bench.sv */
// bench of the execute block: bus tasks, program runs, noted results
`timescale 1ns/1ps
module bcce_top_bench;
   logic        aclk, aresetn, watchdog_clear;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, dm_rdata, n, f;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, st, sh;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] prog_rdata;
   logic [20:0] prog_addr;
   logic [33:0] exp_q [$];
   string       name_q [$];
   int          num_errors, n_checks, k, tw, nw;
   bcce_pkg::bcce_dm_req_t dm_req;
   bcce_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .prog_addr, .prog_rdata, .dm_req, .dm_rdata, .watchdog_clear);
   bcce_partner u_mem (.aclk, .prog_addr, .prog_rdata, .dm_req, .dm_rdata);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [33:0] zst(input logic [31:0] s);
      return 34'(s | (32'h1 << bcce_pkg::ST_Z));
   endfunction
   task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 64) begin
         num_errors++;
         complete_run();
      end
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [33:0] e);
      int i;
      exp_q.push_back(e);
      name_q.push_back(nm);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 64) begin
         num_errors++;
         complete_run();
      end
   endtask
   // no done signal at the ports, so the run window is sized for the longest program
   task automatic run_prog(input logic [31:0] s, input logic [31:0] w, input logic [31:0] b);
      wr(bcce_pkg::REG_PC, 32'h100);
      wr(bcce_pkg::REG_STATUS, s);
      wr(bcce_pkg::REG_WREG, w);
      wr(bcce_pkg::REG_BNK, b);
      wr(bcce_pkg::REG_CTRL, 32'h1);
      repeat (24) @(posedge aclk);
      wr(bcce_pkg::REG_CTRL, 32'h0);
      repeat (12) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      if (watchdog_clear === 1'b1) nw++;
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
         check(name_q.pop_front(), {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      seed = 32'h0554B344;
      sh = 32'h0;
      for (k = 0; k < 1024; k++) u_mem.pmem[k] = 16'h0000;
      for (k = 0; k < 4096; k++) u_mem.dmem[k] = 8'h5A;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd("ctrl", bcce_pkg::REG_CTRL, 34'h0);
      rd("wdog", bcce_pkg::REG_WDOG, 34'h3);
      rd("unmapped", 8'h40, {bcce_pkg::RESP_SLVERR, 32'h0});
      // the unused flag is set opposite, so a swapped condition is caught
      for (k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         n = {seed[7], ~seed[7], seed[5:0]};
         tw = 129 + $signed(n);
         st = (seed & 32'h13) | (32'h1 << ((k[1] == k[0]) ? bcce_pkg::ST_OV : bcce_pkg::ST_Z));
         u_mem.pmem[128] = {k[1] ? bcce_pkg::OPC_BRV : bcce_pkg::OPC_BRZ, n};
         u_mem.pmem[129] = 16'h6A01;
         u_mem.pmem[tw] = 16'h6A02;
         u_mem.dmem[1] = 8'h5A;
         u_mem.dmem[2] = 8'h5A;
         run_prog(st, 32'h0, 32'h0);
         check("fall", 34'(u_mem.dmem[1]), k[0] ? 34'h5A : 34'h0);
         check("jump", 34'(u_mem.dmem[2]), k[0] ? 34'h0 : 34'h5A);
         rd("status", bcce_pkg::REG_STATUS, zst(st));
         u_mem.pmem[tw] = 16'h0000;
      end
      for (k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         st = 32'(seed[12:8]);
         u_mem.pmem[128] = {bcce_pkg::OPC_CALL, k[0], 3'h1, seed[4:0]};
         u_mem.pmem[129] = {4'hF, seed[31:22], 2'h0};
         u_mem.pmem[{3'h1, seed[4:0]}] = 16'h6A03;
         u_mem.dmem[3] = 8'h5A;
         run_prog(st, 32'(seed[7:0]), 32'(seed[19:16]));
         if (k[0]) sh = {12'h0, seed[19:16], 3'h0, seed[12:8], seed[7:0]};
         check("call", 34'(u_mem.dmem[3]), 34'h0);
         rd("stack", bcce_pkg::REG_TOP, {5'h0, 5'(k + 1), 3'h0, 21'h104});
         rd("shadow", bcce_pkg::REG_SHADOW, 34'(sh));
         rd("status", bcce_pkg::REG_STATUS, zst(st));
         u_mem.pmem[{3'h1, seed[4:0]}] = 16'h0000;
      end
      seed = lfsr(seed);
      f = {1'b0, seed[10:4]};
      st = 32'(seed[20:16]);
      u_mem.pmem[128] = bcce_pkg::OPC_CLWD;
      u_mem.pmem[129] = 16'h6A85;
      u_mem.pmem[130] = {bcce_pkg::OPC_CLF, 1'b1, f};
      u_mem.pmem[131] = {bcce_pkg::OPC_TGL, seed[14:12], 1'b1, f + 8'h01};
      u_mem.dmem[{1'b0, seed[2:0], f}] = 8'h5A;
      u_mem.dmem[{1'b0, seed[2:0], f + 8'h01}] = 8'h5A;
      wr(bcce_pkg::REG_WDOG, 32'h3);
      rd("wdog", bcce_pkg::REG_WDOG, 34'h0);
      run_prog(st, seed, {29'h0, seed[2:0]});
      check("access", 34'(u_mem.dmem[12'hF85]), 34'h0);
      check("banked", 34'(u_mem.dmem[{1'b0, seed[2:0], f}]), 34'h0);
      check("toggle", 34'(u_mem.dmem[{1'b0, seed[2:0], f + 8'h01}]),
         34'(8'h5A ^ (8'h01 << seed[14:12])));
      rd("wdog", bcce_pkg::REG_WDOG, 34'h3);
      check("wclr", 34'(nw), 34'h1);
      rd("status", bcce_pkg::REG_STATUS, zst(st));
      repeat (4) @(posedge aclk);
      complete_run();
   end
endmodule
